// [src/vrl_top.sv]
// module: APB register block for the bandgap reference and low-voltage detector
//
// Contract
// - Bandgap powered while brown-out, detector, high or low reference enabled.
// - Read-only stable flag is 1 once bandgap settled, else 0.
// - Detector enable turns detector on and requests bandgap power.
// - Trip select codes 0111/0110/0101 pick 3.0/2.8/2.7V, driven to comparator.
// - Trip code 0100 picks 2.5V, code 0010 picks 3.6V.
// - Clearing low reference enable withdraws its bandgap request.
// - High reference reaches port A pin three only when also enabled.
// - Low reference reaches port A pin two only when also enabled.
// - Reference control bits 3 to 0 read as zero.
// - High reference enable at bit 7, low enable at bit 6.
// - Stable flag bit 5, detector enable bit 4, trip select bits 3:0.
// - Trip code 1111 switches comparator to the external analog pin.
// - Low-voltage flag set at or below trip only once bandgap stable.
`timescale 1ns/1ps
module vrl_top (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic brownoutResetEnable,
  input wire logic bandgapSettled,
  input wire logic tripBelow,
  output logic bandgapPowerUp,
  output logic lowvoltDetectorOn,
  output logic [3:0] tripPointSelect,
  output logic externalTripInput,
  output logic highReferenceOn,
  output logic lowReferenceOn,
  output logic portAPinThreeRef,
  output logic portAPinTwoRef,
  output logic irq
);
  vrl_regs_if regs();
  vrl_pkg::vrl_bg_state_type bgState;
  vrl_pkg::vrl_bg_state_type next_bgState;
  logic [vrl_pkg::EVT_W-1:0] irqStatus;
  logic [vrl_pkg::EVT_W-1:0] irqMask;
  logic [vrl_pkg::EVT_W-1:0] next_irqStatus;
  logic bandgapStableFlag;
  logic [31:0] next_prdata;

  // apb decode: answer in the access cycle, zero wait states
  wire access = psel && penable;
  wire setup = psel && !penable;
  wire hitLvd = paddr == vrl_pkg::LVDCTL_ADDR;
  wire hitRef = paddr == vrl_pkg::REFCTL_ADDR;
  wire hitStat = paddr == vrl_pkg::IRQSTAT_ADDR;
  wire hitMask = paddr == vrl_pkg::IRQMASK_ADDR;
  wire hitAny = hitLvd || hitRef || hitStat || hitMask;
  // writes take effect at the access edge; the low byte lane must be enabled
  wire wrOk = access && pwrite && pstrb[0];
  wire statRead = access && !pwrite && hitStat;

  assign regs.wrLvd = wrOk && hitLvd;
  assign regs.wrRef = wrOk && hitRef;
  assign regs.wdata = pwdata[7:0];

  vrl_ctrl_bank u_bank (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .regs(regs)
  );

  // any consumer keeps the shared bandgap alive
  wire bandgapRequest = brownoutResetEnable || regs.lvdEnable
                        || regs.highEnable || regs.lowEnable;

  // stable tracker: power loss always drops back to off
  always_comb begin
    next_bgState = bgState;
    case (bgState)
      vrl_pkg::BG_OFF: begin
        if (bandgapRequest) next_bgState = vrl_pkg::BG_SETTLING;
      end
      vrl_pkg::BG_SETTLING: begin
        if (!bandgapRequest) next_bgState = vrl_pkg::BG_OFF;
        else if (bandgapSettled) next_bgState = vrl_pkg::BG_STABLE;
      end
      vrl_pkg::BG_STABLE: begin
        if (!bandgapRequest) next_bgState = vrl_pkg::BG_OFF;
        else if (!bandgapSettled) next_bgState = vrl_pkg::BG_SETTLING;
      end
      default: next_bgState = vrl_pkg::BG_OFF;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) bgState <= vrl_pkg::BG_OFF;
    else bgState <= next_bgState;
  end

  assign bandgapStableFlag = bgState == vrl_pkg::BG_STABLE;

  // the flag is held off until the bandgap is trusted, so start-up glitches on the
  // comparator never reach software; software need not keep the mask low meanwhile
  wire lowvoltEvent = regs.lvdEnable && bandgapStableFlag && tripBelow;
  wire stableEvent = (next_bgState == vrl_pkg::BG_STABLE) && !bandgapStableFlag;
  wire [vrl_pkg::EVT_W-1:0] events = (lowvoltEvent ? vrl_pkg::EVT_LOWVOLT : 2'h0)
                                     | (stableEvent ? vrl_pkg::EVT_STABLE : 2'h0);
  // read clears, but an event in the same cycle wins
  assign next_irqStatus = (statRead ? 2'h0 : irqStatus) | events;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irqStatus <= 2'h0;
      irqMask <= 2'h0;
    end else begin
      irqStatus <= next_irqStatus;
      if (wrOk && hitMask) irqMask <= pwdata[vrl_pkg::EVT_W-1:0];
    end
  end

  // read mux; reserved and unimplemented bits read zero
  wire [7:0] lvdRead = {2'h0, bandgapStableFlag, regs.lvdEnable, regs.trip};
  wire [7:0] refRead = {regs.highEnable, regs.lowEnable, regs.highPin, regs.lowPin, 4'h0};
  always_comb begin
    next_prdata = 32'h0;
    if (setup && !pwrite) begin
      if (hitLvd) next_prdata = {24'h0, lvdRead};
      else if (hitRef) next_prdata = {24'h0, refRead};
      else if (hitStat) next_prdata = {30'h0, irqStatus};
      else if (hitMask) next_prdata = {30'h0, irqMask};
    end
  end

  // analog controls: registered so every output comes from a flip-flop
  // codes are passed through; unused ones are the software's to avoid
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      bandgapPowerUp <= 1'b0;
      lowvoltDetectorOn <= 1'b0;
      tripPointSelect <= vrl_pkg::TRIP_RESET;
      externalTripInput <= 1'b0;
      highReferenceOn <= 1'b0;
      lowReferenceOn <= 1'b0;
      portAPinThreeRef <= 1'b0;
      portAPinTwoRef <= 1'b0;
      irq <= 1'b0;
    end else begin
      // read data is captured in setup so it is stable through the access phase
      if (setup) prdata <= next_prdata;
      pready <= setup;
      pslverr <= setup && !hitAny;
      bandgapPowerUp <= bandgapRequest;
      lowvoltDetectorOn <= regs.lvdEnable;
      tripPointSelect <= regs.trip;
      externalTripInput <= regs.trip == vrl_pkg::TRIP_EXTERNAL;
      highReferenceOn <= regs.highEnable;
      lowReferenceOn <= regs.lowEnable;
      portAPinThreeRef <= regs.highPin && regs.highEnable;
      portAPinTwoRef <= regs.lowPin && regs.lowEnable;
      irq <= |(next_irqStatus & irqMask);
    end
  end
endmodule

// [src/vrl_pkg.sv]
// package: register map, field positions, reset values and codes for the reference/low-voltage block
package vrl_pkg;
  localparam int ADDR_W = 12;
  localparam logic [11:0] LVDCTL_ADDR = 12'h000;
  localparam logic [11:0] REFCTL_ADDR = 12'h004;
  localparam logic [11:0] IRQSTAT_ADDR = 12'h008;
  localparam logic [11:0] IRQMASK_ADDR = 12'h00C;
  localparam int BANDGAP_STABLE_FLAG_POS = 5;
  localparam int LOWVOLT_DETECT_ENABLE_POS = 4;
  localparam int TRIP_LSB = 0;
  localparam int TRIP_W = 4;
  localparam int HREN_POS = 7;
  localparam int LREN_POS = 6;
  localparam int HROE_POS = 5;
  localparam int LROE_POS = 4;
  localparam logic [3:0] TRIP_RESET = 4'h5;
  localparam logic [3:0] TRIP_EXTERNAL = 4'hF;
  localparam logic [3:0] TRIP_3V6 = 4'h2;
  localparam logic [3:0] TRIP_3V0 = 4'h7;
  localparam logic [3:0] TRIP_2V8 = 4'h6;
  localparam logic [3:0] TRIP_2V7 = 4'h5;
  localparam logic [3:0] TRIP_2V5 = 4'h4;
  localparam logic [1:0] EVT_LOWVOLT = 2'h1;
  localparam logic [1:0] EVT_STABLE = 2'h2;
  localparam int EVT_W = 2;
  typedef enum logic [2:0] {
    BG_OFF = 3'h1,
    BG_SETTLING = 3'h2,
    BG_STABLE = 3'h4
  } vrl_bg_state_type;
endpackage

// [src/vrl_regs_if.sv]
// interface: decoded register strobes and data between the bus slave and the register bank
`timescale 1ns/1ps
interface vrl_regs_if;
  logic wrLvd;
  logic wrRef;
  logic [7:0] wdata;
  logic [3:0] trip;
  logic lvdEnable;
  logic highEnable;
  logic lowEnable;
  logic highPin;
  logic lowPin;
  modport bank (input wrLvd, wrRef, wdata, output trip, lvdEnable, highEnable, lowEnable, highPin, lowPin);
  modport bus (output wrLvd, wrRef, wdata, input trip, lvdEnable, highEnable, lowEnable, highPin, lowPin);
endinterface

// [src/vrl_ctrl_bank.sv]
// module: writable control bits of both control registers
`timescale 1ns/1ps
module vrl_ctrl_bank (
  input wire logic sys_clk,
  input wire logic rst_n,
  vrl_regs_if.bank regs
);
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      regs.trip <= vrl_pkg::TRIP_RESET;
      regs.lvdEnable <= 1'b0;
      regs.highEnable <= 1'b0;
      regs.lowEnable <= 1'b0;
      regs.highPin <= 1'b0;
      regs.lowPin <= 1'b0;
    end else begin
      if (regs.wrLvd) begin
        regs.trip <= regs.wdata[vrl_pkg::TRIP_LSB +: vrl_pkg::TRIP_W];
        regs.lvdEnable <= regs.wdata[vrl_pkg::LOWVOLT_DETECT_ENABLE_POS];
      end
      if (regs.wrRef) begin
        regs.highEnable <= regs.wdata[vrl_pkg::HREN_POS];
        regs.lowEnable <= regs.wdata[vrl_pkg::LREN_POS];
        regs.highPin <= regs.wdata[vrl_pkg::HROE_POS];
        regs.lowPin <= regs.wdata[vrl_pkg::LROE_POS];
      end
    end
  end
endmodule

// [testbench/vrl_top_properties.sv]
// checker: port-level properties of the reference and low-voltage register block
`timescale 1ns/1ps
module vrl_top_properties (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic brownoutResetEnable,
  input wire logic bandgapSettled,
  input wire logic bandgapPowerUp,
  input wire logic lowvoltDetectorOn,
  input wire logic [3:0] tripPointSelect,
  input wire logic externalTripInput,
  input wire logic highReferenceOn,
  input wire logic lowReferenceOn,
  input wire logic portAPinThreeRef,
  input wire logic portAPinTwoRef
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // two-sample windows absorb the one-cycle lag of the registered power request
  bg_power_on_a: assert property (
    (brownoutResetEnable || lowvoltDetectorOn || highReferenceOn || lowReferenceOn) [*2] |-> bandgapPowerUp)
    else $error("bandgap off while requested");
  bg_power_off_a: assert property (
    (!(brownoutResetEnable || lowvoltDetectorOn || highReferenceOn || lowReferenceOn)) [*2] |-> !bandgapPowerUp)
    else $error("bandgap on with no request");
  pin_three_gate_a: assert property ((!highReferenceOn) [*2] |-> !portAPinThreeRef)
    else $error("high reference on pin while disabled");
  pin_two_gate_a: assert property ((!lowReferenceOn) [*2] |-> !portAPinTwoRef)
    else $error("low reference on pin while disabled");
  ext_trip_a: assert property (
    $stable(tripPointSelect) |-> externalTripInput == (tripPointSelect == 4'hF))
    else $error("external input select wrong");
  ref_low_zero_a: assert property (
    pready && !pwrite && paddr == vrl_pkg::REFCTL_ADDR |-> prdata[3:0] == 4'h0)
    else $error("reference low nibble not zero");
  stable_power_a: assert property (
    (!bandgapPowerUp) [*3] ##0 (psel && !penable && !pwrite && paddr == vrl_pkg::LVDCTL_ADDR) |=> !prdata[5])
    else $error("stable flag set while unpowered");
  stable_settle_a: assert property (
    (!bandgapSettled) [*3] ##0 (psel && !penable && !pwrite && paddr == vrl_pkg::LVDCTL_ADDR) |=> !prdata[5])
    else $error("stable flag set before settling");
endmodule
bind vrl_top vrl_top_properties u_props (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .brownoutResetEnable(brownoutResetEnable),
  .bandgapSettled(bandgapSettled), .bandgapPowerUp(bandgapPowerUp), .lowvoltDetectorOn(lowvoltDetectorOn),
  .tripPointSelect(tripPointSelect), .externalTripInput(externalTripInput), .highReferenceOn(highReferenceOn),
  .lowReferenceOn(lowReferenceOn), .portAPinThreeRef(portAPinThreeRef), .portAPinTwoRef(portAPinTwoRef));

// [testbench/vrl_top_tb_top.sv]
// testbench: register and pin checks of the reference and low-voltage block
`timescale 1ns/1ps
module vrl_top_tb_top;
  logic sysClk = 0, rstN = 0, psel = 0, penable = 0, pwrite = 0, bor = 0, stl = 0, blw = 0, e;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, q;
  logic [3:0] trip;
  logic pready, pslverr;
  logic [3:0] codes [6] = '{4'h7, 4'h6, 4'h5, 4'h4, 4'h2, 4'hF};
  wire [7:0] outs;
  int nFail = 0, testsRun = 0;
  always #2.5 sysClk = ~sysClk;
  vrl_top dut (.sys_clk(sysClk), .rst_n(rstN), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr), .brownoutResetEnable(bor),
    .bandgapSettled(stl), .tripBelow(blw), .bandgapPowerUp(outs[7]), .lowvoltDetectorOn(outs[6]),
    .tripPointSelect(trip), .externalTripInput(outs[1]), .highReferenceOn(outs[5]), .lowReferenceOn(outs[4]),
    .portAPinThreeRef(outs[3]), .portAPinTwoRef(outs[2]), .irq(outs[0]));
  task automatic conclude;
    $display("checks %0d mismatches %0d", testsRun, nFail);
    if (nFail == 0 && testsRun > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
    testsRun++;
    if (seen !== exp) begin
      nFail++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one APB transfer; pready, prdata and pslverr are taken at the rising edge that completes it
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge sysClk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sysClk);
    penable <= 1;
    n = 0;
    do begin
      @(posedge sysClk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      nFail++;
      conclude();
    end
    q = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic rc(input logic [11:0] a, input logic [31:0] exp);
    xfer(0, a, 0);
    chk(q, exp);
  endtask
  // outputs follow a write one edge after it takes effect
  task automatic co(input logic [7:0] exp);
    repeat (2) @(negedge sysClk);
    chk(outs, exp);
    @(posedge sysClk);
  endtask
  initial begin
    repeat (8) @(posedge sysClk);
    rstN <= 1;
    rc(vrl_pkg::LVDCTL_ADDR, 32'h05);
    rc(vrl_pkg::REFCTL_ADDR, 0);
    chk({trip, outs}, 12'h500);
    xfer(1, vrl_pkg::LVDCTL_ADDR, 32'h17);
    blw <= 1;
    co(8'hC0);
    rc(vrl_pkg::IRQSTAT_ADDR, 0);
    rc(vrl_pkg::LVDCTL_ADDR, 32'h17);
    blw <= 0;
    stl <= 1;
    xfer(1, vrl_pkg::IRQMASK_ADDR, 32'h1);
    rc(vrl_pkg::LVDCTL_ADDR, 32'h37);
    blw <= 1;
    co(8'hC1);
    rc(vrl_pkg::IRQSTAT_ADDR, 32'h3);
    blw <= 0;
    rc(vrl_pkg::IRQSTAT_ADDR, 32'h1);
    rc(vrl_pkg::IRQSTAT_ADDR, 0);
    co(8'hC0);
    foreach (codes[i]) begin
      xfer(1, vrl_pkg::LVDCTL_ADDR, {28'h1, codes[i]});
      co(8'hC0 | {6'h0, codes[i] == 4'hF, 1'b0});
      chk(trip, codes[i]);
    end
    xfer(1, vrl_pkg::LVDCTL_ADDR, 32'h05);
    co(0);
    rc(vrl_pkg::LVDCTL_ADDR, 32'h05);
    xfer(1, vrl_pkg::REFCTL_ADDR, 32'h3F);
    rc(vrl_pkg::REFCTL_ADDR, 32'h30);
    co(0);
    xfer(1, vrl_pkg::REFCTL_ADDR, 32'hF0);
    co(8'hBC);
    rc(vrl_pkg::LVDCTL_ADDR, 32'h25);
    xfer(1, vrl_pkg::REFCTL_ADDR, 32'h50);
    co(8'h94);
    xfer(1, vrl_pkg::REFCTL_ADDR, 0);
    co(0);
    bor <= 1;
    co(8'h80);
    xfer(0, 12'h010, 0);
    chk({e, q}, 33'h100000000);
    conclude();
  end
endmodule
